// ### tb/cfg_host_model.sv
// ------------------------------------------------------------
// Configuration host on the far side of the register bank
// ------------------------------------------------------------
module cfg_host_model (
    // Clock
    input wire logic i_clk,
    // Configuration strobes and payload
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [3:0] o_be,
    output logic [31:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_be = 4'h0;
        o_wdata = 32'h00000000;
    end

    // One dword access; strobe held for exactly one edge
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [3:0] b, input logic [31:0] d);
        @(posedge i_clk);
        o_wr <= w;
        o_rd <= r;
        o_addr <= a;
        o_be <= b;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        // Released address and data show inverted values so stale data never matches; byte enables go to zero
        o_addr <= ~a;
        o_be <= 4'h0;
        o_wdata <= ~d;
    endtask
endmodule

// ### tb/tb_top.sv
// ------------------------------------------------------------
// Self-checking bench for the configuration header bank
// ------------------------------------------------------------
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value
    logic i_clk, i_sys_rst, rev, pcix, pv, probe_pend; // Stimulus and monitor state
    logic [31:0] setup, xlat, pa, er, base, off, msk, o_rdata, o_fwd_addr;
    logic [31:0] o_wbase, o_wmask;
    logic [7:0] lat, ls;
    logic [15:0] hi;
    logic [33:0] ep; // {csr, fwd, address}
    logic wr_s, rd_s, o_rvalid, o_csr_hit, o_fwd_hit;
    logic [7:0] addr_s;
    logic [3:0] be_s, o_line_size;
    logic [7:0] o_latency_timer;
    logic [31:0] wdata_s;
    logic [31:0] rq[$]; // Expected read data, oldest first
    logic [33:0] pq[$]; // Expected decode results
    int mismatches, num_checks, seed;
    int sizes[3] = '{12, 16, 31}; // Window sizes as powers of two

    always #5 i_clk = ~i_clk;

    cfg_host_model u_host (.i_clk(i_clk), .o_wr(wr_s), .o_rd(rd_s), .o_addr(addr_s),
        .o_be(be_s), .o_wdata(wdata_s));

    bridge_config_header_regs #(.REVISION(REV)) u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_cfg_wr(wr_s), .i_cfg_rd(rd_s), .i_cfg_addr(addr_s), .i_cfg_be(be_s),
        .i_cfg_wdata(wdata_s), .o_cfg_rdata(o_rdata), .o_cfg_rvalid(o_rvalid),
        .i_reverse(rev), .i_pcix_mode(pcix), .i_mem0_setup(setup), .i_xlat_base(xlat),
        .o_line_size(o_line_size), .o_latency_timer(o_latency_timer),
        .o_window_base(o_wbase), .o_window_mask(o_wmask), .i_probe_valid(pv),
        .i_probe_addr(pa), .o_csr_hit(o_csr_hit), .o_fwd_hit(o_fwd_hit),
        .o_fwd_addr(o_fwd_addr));

    // ------------------------------------------------------------
    // Monitor: pops the oldest note whenever a result appears
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (o_rvalid === 1'b1) begin
            if (rq.size() == 0) `CHK("rvalid_extra", 1'b0, 1'b1)
            else begin
                er = rq.pop_front();
                `CHK("rdata", er, o_rdata)
            end
        end
        // Decode answers stand from the edge after the probe
        if (probe_pend && pq.size() != 0) begin
            ep = pq.pop_front();
            `CHK("csr_hit", ep[33], o_csr_hit)
            `CHK("fwd_hit", ep[32], o_fwd_hit)
            if (ep[32]) `CHK("fwd_addr", ep[31:0], o_fwd_addr)
        end
        probe_pend <= pv;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        u_host.access(1'b0, 1'b1, a, 4'h0, $urandom);
    endtask

    // Waits past the taking edge so registered outputs have landed
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        u_host.access(1'b1, 1'b0, a, b, d);
        #1;
    endtask

    task automatic probe(input logic [31:0] a, input logic [33:0] e);
        pq.push_back(e);
        pv <= 1'b1;
        pa <= a;
        @(posedge i_clk);
    endtask

    // Bounded wait for all notes to be consumed
    task automatic drain(input string nm);
        int n;
        n = 0;
        while ((rq.size() != 0 || pq.size() != 0) && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        if (rq.size() != 0 || pq.size() != 0) begin
            mismatches++;
            summarize();
        end else begin
            $display("test %s done", nm);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        i_sys_rst = 1'b1;
        rev = 1'b1;
        pcix = 1'b1;
        setup = 32'h00000000;
        xlat = 32'h00000000;
        pv = 1'b0;
        pa = 32'h00000000;
        mismatches = 0;
        num_checks = 0;
        seed = $urandom(84);
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        rd(8'h08, {8'h06, 8'h80, 8'h00, REV});
        rd(8'h0C, 32'h00004000);
        rd(8'h10, 32'h00000000);
        drain("reset_values");
        // Each one-hot line size code, with read-only bits written high and header bytes random
        for (int k = 0; k < 4; k++) begin
            lat = $urandom;
            hi = $urandom;
            ls = 8'h04 << k;
            wr(8'h0C, 4'hF, {hi, lat, ls | 8'hC3}); // One line size bit
            `CHK("line_size", ls[5:2], o_line_size)
            `CHK("latency", lat, o_latency_timer)
            rd(8'h0C, {16'h0000, lat, ls});
        end
        // Read and write in one cycle: the read sees the old value
        rq.push_back({16'h0000, lat, 8'h20});
        u_host.access(1'b1, 1'b1, 8'h0C, 4'h1, 32'h00000008);
        rd(8'h0C, {16'h0000, lat, 8'h08});
        drain("line_size");
        // Forward bridge: latency fixed at zero
        rev <= 1'b0;
        wr(8'h0C, 4'h2, 32'h00007700);
        `CHK("latency_fwd", 8'h00, o_latency_timer)
        rd(8'h0C, 32'h00000008);
        // Unmapped offset ignores writes and reads zero
        wr(8'h14, 4'hF, $urandom);
        rd(8'h14, 32'h00000000);
        rd(8'h08, {8'h06, 8'h80, 8'h00, REV});
        drain("forward_unmapped");
        // Window sizes from the smallest page up to 2GB
        foreach (sizes[i]) begin
            msk = 32'hFFFFFFFF << sizes[i];
            setup <= msk | ($urandom & 32'h00000FFF);
            xlat <= $urandom;
            wr(8'h10, 4'hF, 32'hFFFFFFFF);
            `CHK("window_mask", msk, o_wmask)
            rd(8'h10, msk);
            base = $urandom & msk;
            wr(8'h10, 4'hF, base | 32'h00000FFF);
            `CHK("window_base", base, o_wbase)
            rd(8'h10, base);
            off = $urandom & 32'h00000FFF;
            probe(base | off, {2'b10, 32'h00000000});
            if (sizes[i] > 12) begin
                off = ($urandom & ~msk) | 32'h00001000;
                probe(base | off, {2'b01, (xlat & msk) | off});
            end
            probe(base ^ 32'h80000000, {2'b00, 32'h00000000});
            pv <= 1'b0;
            pa <= ~pa;
            drain("window");
        end
        // No window programmed: nothing decodes
        setup <= 32'h00000000;
        wr(8'h10, 4'hF, 32'h00000000);
        @(posedge i_clk);
        probe(32'h00000000, {2'b00, 32'h00000000});
        pv <= 1'b0;
        drain("no_window");
        // Second reset, reverse bridge with primary bus in PCI mode
        rev <= 1'b1;
        pcix <= 1'b0;
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        setup <= 32'hFFFFF000;
        @(posedge i_clk);
        rd(8'h0C, 32'h00000000);
        rd(8'h10, 32'h00000000);
        drain("second_reset");
        summarize();
    end
endmodule

// ### verilog/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses of configuration dwords)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CLASS_REV = 8'h08;
    localparam logic [7:0] OFS_LINE_HDR = 8'h0C;
    localparam logic [7:0] OFS_WINDOW_BAR = 8'h10;

    // ------------------------------------------------------------
    // Fixed field values
    // ------------------------------------------------------------
    localparam logic [7:0] PROG_IF_VAL = 8'h00;
    localparam logic [7:0] SUB_CLASS_VAL = 8'h80;
    localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
    localparam logic [7:0] HEADER_VAL = 8'h00;
    localparam logic [7:0] RSVD_BYTE_VAL = 8'h00;
    localparam logic [3:0] BAR_TYPE_VAL = 4'h0;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int LINE_LSB = 2;
    localparam int LINE_W = 4;
    localparam int LAT_LSB = 8;
    localparam int LAT_W = 8;
    localparam int BASE_LSB = 12;
    localparam int BASE_W = 20;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [LINE_W-1:0] LINE_RST = 4'h0;
    localparam logic [LAT_W-1:0] LAT_RST_PCI = 8'h00;
    localparam logic [LAT_W-1:0] LAT_RST_PCIX = 8'h40;
    localparam logic [LAT_W-1:0] LAT_FORWARD = 8'h00;
    localparam logic [BASE_W-1:0] BASE_RST = 20'h00000;

    // ------------------------------------------------------------
    // State of the configuration bank
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LINE_W-1:0] line;
        logic [LAT_W-1:0] lat;
        logic [BASE_W-1:0] base;
        logic [31:0] rdata;
        logic rvalid;
    } cfg_state_t;

    // State of the window decoder
    typedef struct packed {
        logic csr_hit;
        logic fwd_hit;
        logic [31:0] fwd_addr;
    } dec_state_t;

endpackage

// ### verilog/bridge_config_header_regs.sv
// Overview of operation
// - Class code bytes read fixed bridge values
// - Line size bits 1:0 read zero
// - Line size bits 5:2 writable, reset zero
// - Line size bits 7:6 read zero
// - Forward bridge: latency timer reads zero
// - Reverse bridge: latency writable, mode reset value
// - Header type bits 22:16 read zero
// - Header bit 23 zero: single function
// - Window register: memory space, 32-bit type
// - Window register reads non-prefetchable
// - Window size comes from setup input
// - Window 4KB to 2GB, base resets zero
// - Bottom 4KB reaches own registers
// - Rest of window forwards downstream
// - Forwarding uses translated base input
// - Base bit writable only if setup bit
module bridge_config_header_regs #(
    // Silicon revision; the value is arbitrary
    parameter logic [7:0] REVISION = 8'h5A
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Configuration access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // Bridge mode
    input wire logic i_reverse,
    input wire logic i_pcix_mode,
    // Window setup and translation
    input wire logic [31:0] i_mem0_setup,
    input wire logic [31:0] i_xlat_base,
    // Programmed values toward the bridge
    output logic [3:0] o_line_size,
    output logic [7:0] o_latency_timer,
    output logic [31:0] o_window_base,
    output logic [31:0] o_window_mask,
    // Address decode
    input wire logic i_probe_valid,
    input wire logic [31:0] i_probe_addr,
    output logic o_csr_hit,
    output logic o_fwd_hit,
    output logic [31:0] o_fwd_addr
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bridge_cfg_pkg::cfg_state_t cur;  // Registered bank state
    bridge_cfg_pkg::cfg_state_t next_cur;
    logic [31:0] lane_mask;     // Byte enables spread to bits
    logic [19:0] size_mask;     // Base bits that software may change
    logic [7:0] lat_reset;      // Latency value taken at reset
    logic [31:0] read_word;     // Word selected by the read offset
    logic [31:0] bar_word;      // Window register as read back
    logic [31:0] line_word;     // Line size, latency, header dword
    logic [31:0] class_word;    // Revision and class code dword
    logic wr_line;              // Write to the line size dword
    logic wr_bar;               // Write to the window register
    logic [19:0] base_wr;       // Base bits hit by this write

    // Bundle toward the decoder; it sees only the decoder view
    window_if win ();

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------

    // One mask bit per data bit, so each byte lane stands alone
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{i_cfg_be[lane]}};
        end
    endgenerate

    // A setup mask with holes splits the window; setup must avoid it
    // Only setup bits set to one open a base bit for writing
    assign size_mask = i_mem0_setup[31:12];
    assign wr_line = i_cfg_wr && (i_cfg_addr == bridge_cfg_pkg::OFS_LINE_HDR);
    assign wr_bar = i_cfg_wr && (i_cfg_addr == bridge_cfg_pkg::OFS_WINDOW_BAR);
    assign base_wr = lane_mask[31:12] & size_mask;

    // Reset value of the latency timer depends on direction and bus mode.
    // Sampling mode inputs here is safe: the reset is synchronous.
    always_comb begin
        if (i_reverse && i_pcix_mode) begin
            lat_reset = bridge_cfg_pkg::LAT_RST_PCIX;
        end else begin
            lat_reset = bridge_cfg_pkg::LAT_RST_PCI;
        end
    end

    // ------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------

    // Revision and class code never change
    assign class_word = {bridge_cfg_pkg::BASE_CLASS_VAL,
        bridge_cfg_pkg::SUB_CLASS_VAL,
        bridge_cfg_pkg::PROG_IF_VAL,
        REVISION};

    // Unused line size bits and the whole header byte read zero
    assign line_word = {bridge_cfg_pkg::RSVD_BYTE_VAL,
        bridge_cfg_pkg::HEADER_VAL,
        cur.lat,
        2'b00, cur.line, 2'b00};

    // Base bits outside the window size always read zero, which is
    // what lets software size the window by writing all ones
    assign bar_word = {cur.base & size_mask,
        8'h00,
        bridge_cfg_pkg::BAR_TYPE_VAL};

    // Offset select; anything not in this bank reads zero
    always_comb begin
        case (i_cfg_addr)
            bridge_cfg_pkg::OFS_CLASS_REV: read_word = class_word;
            bridge_cfg_pkg::OFS_LINE_HDR: read_word = line_word;
            bridge_cfg_pkg::OFS_WINDOW_BAR: read_word = bar_word;
            default: read_word = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.rvalid = i_cfg_rd;
        // A read and a write in one cycle return the value before the write
        // Read data is captured once, held until the next read
        if (i_cfg_rd) begin
            next_cur.rdata = read_word;
        end
        // Line size bits 5:2; bits 1:0 and 7:6 are not stored
        if (wr_line && i_cfg_be[0]) begin
            next_cur.line =
                i_cfg_wdata[bridge_cfg_pkg::LINE_LSB +: bridge_cfg_pkg::LINE_W];
        end
        // Latency timer only accepts writes on a reverse bridge
        if (!i_reverse) begin
            next_cur.lat = bridge_cfg_pkg::LAT_FORWARD;
        end else if (wr_line && i_cfg_be[1]) begin
            next_cur.lat =
                i_cfg_wdata[bridge_cfg_pkg::LAT_LSB +: bridge_cfg_pkg::LAT_W];
        end
        // Base bits change only where lane and size both allow
        if (wr_bar) begin
            next_cur.base = (cur.base & ~base_wr)
                | (i_cfg_wdata[bridge_cfg_pkg::BASE_LSB +: bridge_cfg_pkg::BASE_W] & base_wr);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Only the timer's reset value depends on pins; all else is fixed
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cur.line <= bridge_cfg_pkg::LINE_RST;
            cur.lat <= lat_reset;
            cur.base <= bridge_cfg_pkg::BASE_RST;
            cur.rdata <= 32'h00000000;
            cur.rvalid <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Window decoder
    // ------------------------------------------------------------

    // Window spans from one 4KB page up to bit 31 alone (2GB)
    assign win.base = cur.base & size_mask;
    assign win.mask = size_mask;
    assign win.xlat_base = i_xlat_base[31:12];
    assign win.probe_valid = i_probe_valid;
    assign win.probe_addr = i_probe_addr;

    window_decoder u_decoder (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .win(win)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_cfg_rdata = cur.rdata;
    assign o_cfg_rvalid = cur.rvalid;
    // Several set bits is a software fault; value is passed as is
    assign o_line_size = cur.line;
    assign o_latency_timer = cur.lat;
    assign o_window_base = bar_word;
    assign o_window_mask = {size_mask, 12'h000};
    // Decode results are registered inside the decoder
    assign o_csr_hit = win.csr_hit;
    assign o_fwd_hit = win.fwd_hit;
    assign o_fwd_addr = win.fwd_addr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // All checks run on the bank clock and pause while reset is high
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_rd_class;
        i_cfg_rd && i_cfg_addr == bridge_cfg_pkg::OFS_CLASS_REV;
    endsequence

    sequence s_rd_line;
        i_cfg_rd && i_cfg_addr == bridge_cfg_pkg::OFS_LINE_HDR;
    endsequence

    sequence s_rd_bar;
        i_cfg_rd && i_cfg_addr == bridge_cfg_pkg::OFS_WINDOW_BAR;
    endsequence

    sequence s_line_write;
        wr_line && i_cfg_be[0];
    endsequence

    sequence s_lat_write;
        wr_line && i_cfg_be[1] && i_reverse;
    endsequence

    sequence s_lat_write_fwd;
        wr_line && i_cfg_be[1] && !i_reverse;
    endsequence

    sequence s_reset_end;
        $fell(i_sys_rst);
    endsequence

    a_class_code_fixed: assert property (
        s_rd_class |=> o_cfg_rvalid && o_cfg_rdata[31:8] == 24'h068000)
        else $error("class code read back wrong");

    a_line_low_zero: assert property (
        s_rd_line |=> o_cfg_rvalid && o_cfg_rdata[1:0] == 2'b00)
        else $error("line size bits 1:0 not zero");

    a_line_write_take: assert property (
        s_line_write |=> o_line_size == $past(i_cfg_wdata[5:2]))
        else $error("line size write not taken");

    a_line_high_zero: assert property (
        s_rd_line |=> o_cfg_rdata[7:6] == 2'b00)
        else $error("line size bits 7:6 not zero");

    a_lat_forward_zero: assert property (
        !i_reverse ##1 !i_reverse |-> o_latency_timer == 8'h00)
        else $error("forward latency timer not zero");

    a_lat_reverse_write: assert property (
        s_lat_write ##1 i_reverse |-> o_latency_timer == $past(i_cfg_wdata[15:8]))
        else $error("reverse latency write not taken");

    a_header_zero: assert property (
        s_rd_line |=> o_cfg_rdata[31:16] == 16'h0000)
        else $error("header type not zero");

    a_bar_type_zero: assert property (
        s_rd_bar |=> o_cfg_rdata[11:0] == 12'h000)
        else $error("window type bits not zero");

    a_base_ro_bits: assert property (
        $stable(i_mem0_setup) |-> ((cur.base ^ $past(cur.base)) & ~size_mask)
            == 20'h00000)
        else $error("read-only base bit changed");

    a_base_write_take: assert property (
        wr_bar && i_cfg_be == 4'hF |=> (cur.base & $past(size_mask))
            == ($past(i_cfg_wdata[31:12]) & $past(size_mask)))
        else $error("writable base bits not taken");

    // ------------------------------------------------------------
    // Checks on read-back fields
    // ------------------------------------------------------------

    // Bit 23 alone reports whether other functions exist
    a_header_single_fn: assert property (
        s_rd_line |=> o_cfg_rdata[23] == 1'b0)
        else $error("header reports several functions");

    // A set bit 3 would allow prefetch into the register page
    a_bar_prefetch_zero: assert property (
        s_rd_bar |=> o_cfg_rdata[3] == 1'b0)
        else $error("window reads prefetchable");

    // Read data is the stored value from before any same-cycle write
    a_line_read_back: assert property (
        s_rd_line |=> o_cfg_rdata[5:2] == $past(cur.line))
        else $error("line size read back wrong");

    // Unsized base bits stay hidden so sizing reads see the mask
    a_bar_read_base: assert property (
        s_rd_bar |=> o_cfg_rdata[31:12] == ($past(cur.base) & $past(size_mask)))
        else $error("window base read back wrong");

    // ------------------------------------------------------------
    // Checks on ignored writes
    // ------------------------------------------------------------

    // Forward bridge keeps the timer at zero whatever is written
    a_lat_forward_ro: assert property (
        s_lat_write_fwd |=> o_latency_timer == bridge_cfg_pkg::LAT_FORWARD)
        else $error("forward latency write was taken");

    // Only a write to the window offset may move the base
    a_base_hold_idle: assert property (
        !wr_bar |=> $stable(cur.base))
        else $error("base changed without a write");

    // ------------------------------------------------------------
    // Checks on values after reset
    // ------------------------------------------------------------

    // First edge out of reset still shows what reset loaded
    a_line_reset_zero: assert property (
        s_reset_end |-> o_line_size == bridge_cfg_pkg::LINE_RST)
        else $error("line size not zero after reset");

    a_base_reset_zero: assert property (
        s_reset_end |-> cur.base == bridge_cfg_pkg::BASE_RST)
        else $error("window base not zero after reset");

    // Timer reset value follows the mode seen at the last reset edge
    a_lat_reset_value: assert property (
        s_reset_end |-> o_latency_timer == (($past(i_reverse) && $past(i_pcix_mode))
            ? bridge_cfg_pkg::LAT_RST_PCIX : bridge_cfg_pkg::LAT_RST_PCI))
        else $error("latency timer reset value wrong");

endmodule

// ### verilog/window_decoder.sv
module window_decoder (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Window and probe
    window_if.dec win
);

    // ------------------------------------------------------------
    // Decode state
    // ------------------------------------------------------------
    bridge_cfg_pkg::dec_state_t cur;  // Registered decode result
    bridge_cfg_pkg::dec_state_t next_cur;
    logic enabled;            // A window of at least one page exists
    logic [19:0] page;        // Probe address bits 31:12
    logic in_window;          // Sized bits match the base
    logic [19:0] offset_page; // Page index inside the window

    assign page = win.probe_addr[31:12];
    assign enabled = |win.mask;
    assign in_window = ((page ^ win.base) & win.mask) == 20'h00000;
    assign offset_page = page & ~win.mask;

    // Result of one probe, held until the next probe
    always_comb begin
        next_cur = cur;
        if (win.probe_valid) begin
            // Bottom page of the window reaches the own registers
            next_cur.csr_hit = enabled && in_window
                && (offset_page == 20'h00000);
            // Everything above the first page is forwarded
            next_cur.fwd_hit = enabled && in_window
                && (offset_page != 20'h00000);
            // Direct translation: sized bits swapped for the translated base
            next_cur.fwd_addr = {(win.xlat_base & win.mask) | offset_page,
                win.probe_addr[11:0]};
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign win.csr_hit = cur.csr_hit;
    assign win.fwd_hit = cur.fwd_hit;
    assign win.fwd_addr = cur.fwd_addr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_csr_page_hit: assert property (
        win.probe_valid && enabled && in_window && offset_page == 20'h00000
        |=> win.csr_hit && !win.fwd_hit)
        else $error("bottom page of window did not reach own registers");

    a_fwd_range_hit: assert property (
        win.probe_valid && enabled && in_window && offset_page != 20'h00000
        |=> win.fwd_hit && !win.csr_hit)
        else $error("upper window range was not forwarded");

    a_no_window_miss: assert property (
        win.probe_valid && !enabled |=> !win.csr_hit && !win.fwd_hit)
        else $error("decode hit with no window sized");

endmodule

// ### verilog/window_if.sv
// Carries the programmed window and one probe address to the decoder
interface window_if;
    logic [19:0] base;      // Window base, address bits 31:12
    logic [19:0] mask;      // Writable base bits, sets the window size
    logic [19:0] xlat_base; // Translated base, address bits 31:12
    logic probe_valid;      // Address presented for decode
    logic [31:0] probe_addr;
    logic csr_hit;          // Address lands in the own CSR page
    logic fwd_hit;          // Address lands in the forwarded range
    logic [31:0] fwd_addr;  // Translated downstream address

    modport cfg (
        output base, mask, xlat_base, probe_valid, probe_addr,
        input csr_hit, fwd_hit, fwd_addr
    );
    modport dec (
        input base, mask, xlat_base, probe_valid, probe_addr,
        output csr_hit, fwd_hit, fwd_addr
    );
endinterface
